/* File: rtl/ppfm_pkg.sv */
// shared constants and types for the port pin function mux
package ppfm_pkg;

   // function select codes, gpio is code zero so reset lands on it
   localparam logic [1:0] PPFM_SEL_GPIO  = 2'h0;
   localparam logic [1:0] PPFM_SEL_ALT1  = 2'h1;
   localparam logic [1:0] PPFM_SEL_ALT2  = 2'h2;
   localparam logic [1:0] PPFM_SEL_ALT3  = 2'h3;
   localparam logic [1:0] PPFM_SEL_RESET = PPFM_SEL_GPIO;

   // pin a5: gpio, motor out five, timer three, fault two
   // pin a6: gpio, fault zero, timer zero
   // pin b0: gpio, spi clock, i2c clock
   // pin b1: gpio, spi slave select, i2c data
   localparam int PPFM_NUM_PINS = 4;
   localparam int PPFM_PIN_A5   = 0;
   localparam int PPFM_PIN_A6   = 1;
   localparam int PPFM_PIN_B0   = 2;
   localparam int PPFM_PIN_B1   = 3;

   // inactive levels seen by unselected peripheral inputs
   localparam logic PPFM_FAULT_IDLE = 1'b0;
   localparam logic PPFM_TIMER_IDLE = 1'b0;
   localparam logic PPFM_SCLK_IDLE  = 1'b0;
   localparam logic PPFM_SS_IDLE_N  = 1'b1;
   localparam logic PPFM_I2C_IDLE   = 1'b1;

   // reset values of gpio state
   localparam logic [3:0] PPFM_DIR_RESET = 4'h0;
   localparam logic [3:0] PPFM_OUT_RESET = 4'h0;

   typedef logic [1:0] ppfm_sel_t;

endpackage

/* File: rtl/ppfm_pin_cell.sv */
// one pad-side cell: picks drive value and enable for a pin
`timescale 1ns/1ps
`default_nettype none
module ppfm_pin_cell (
   // selected function drive
   input  wire logic drv_i,
   input  wire logic drv_en_i,
   // pad side, enable active low
   output logic      pad_o,
   output logic      pad_oe_n_o
);
   // open pad whenever the function does not drive
   always_comb begin
      pad_o      = drv_en_i ? drv_i : 1'b0;
      pad_oe_n_o = ~drv_en_i;
   end
endmodule
`default_nettype wire

/* File: rtl/ppfm_mux.sv */
// pin function mux for pins a5, a6, b0 and b1
`timescale 1ns/1ps
`default_nettype none
module ppfm_mux
   import ppfm_pkg::*;
#(
   parameter int NUM_PINS = ppfm_pkg::PPFM_NUM_PINS
) (
   // clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 sys_rst_i,
   // selection from system_integration_unit, loaded on write strobe
   input  wire logic                 sel_wr_i,
   input  wire ppfm_pkg::ppfm_sel_t  sel_a5_i,
   input  wire ppfm_pkg::ppfm_sel_t  sel_a6_i,
   input  wire ppfm_pkg::ppfm_sel_t  sel_b0_i,
   input  wire ppfm_pkg::ppfm_sel_t  sel_b1_i,
   output logic [1:0]                sel_a5_o,
   output logic [1:0]                sel_a6_o,
   output logic [1:0]                sel_b0_o,
   output logic [1:0]                sel_b1_o,
   // gpio control, bit order a5 a6 b0 b1
   input  wire logic                 gpio_wr_i,
   input  wire logic [NUM_PINS-1:0]  gpio_dir_i,
   input  wire logic [NUM_PINS-1:0]  gpio_out_i,
   output logic [NUM_PINS-1:0]       gpio_dir_o,
   output logic [NUM_PINS-1:0]       gpio_in_o,
   // motor output unit
   input  wire logic                 motor_output_five_i,
   output logic                      ext_fault_in_zero_o,
   output logic                      ext_fault_in_two_o,
   // timer unit
   input  wire logic                 timer_chan_three_i,
   input  wire logic                 timer_chan_three_oe_i,
   output logic                      timer_chan_three_o,
   input  wire logic                 timer_chan_zero_i,
   input  wire logic                 timer_chan_zero_oe_i,
   output logic                      timer_chan_zero_o,
   output logic                      timer_chan_zero_on_a6_o,
   // queued_serial_unit
   input  wire logic                 spi_master_i,
   input  wire logic                 spi_clock_i,
   output logic                      spi_clock_o,
   output logic                      spi_slave_select_n_o,
   // i2c unit, open drain: drives low only
   input  wire logic                 i2c_scl_low_i,
   input  wire logic                 i2c_sda_low_i,
   output logic                      i2c_scl_o,
   output logic                      i2c_sda_o,
   // pads, enable active low
   input  wire logic [NUM_PINS-1:0]  pad_i,
   output logic [NUM_PINS-1:0]       pad_o,
   output logic [NUM_PINS-1:0]       pad_oe_n_o
);

   ////////////////////////////////////////////////////////////////////////////
   // selection and gpio state
   ppfm_sel_t            sel_a5_q, sel_a5_d;
   ppfm_sel_t            sel_a6_q, sel_a6_d;
   ppfm_sel_t            sel_b0_q, sel_b0_d;
   ppfm_sel_t            sel_b1_q, sel_b1_d;
   logic [NUM_PINS-1:0]  dir_q, dir_d;
   logic [NUM_PINS-1:0]  out_q, out_d;

   always_comb begin
      sel_a5_d = sel_a5_q;
      sel_a6_d = sel_a6_q;
      sel_b0_d = sel_b0_q;
      sel_b1_d = sel_b1_q;
      if (sel_wr_i) begin
         sel_a5_d = sel_a5_i;
         sel_a6_d = sel_a6_i;
         sel_b0_d = sel_b0_i;
         sel_b1_d = sel_b1_i;
      end
   end

   always_comb begin
      dir_d = dir_q;
      out_d = out_q;
      if (gpio_wr_i) begin
         dir_d = gpio_dir_i;
         out_d = gpio_out_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sel_a5_q <= PPFM_SEL_RESET;
         sel_a6_q <= PPFM_SEL_RESET;
         sel_b0_q <= PPFM_SEL_RESET;
         sel_b1_q <= PPFM_SEL_RESET;
         dir_q    <= PPFM_DIR_RESET;
         out_q    <= PPFM_OUT_RESET;
      end else begin
         sel_a5_q <= sel_a5_d;
         sel_a6_q <= sel_a6_d;
         sel_b0_q <= sel_b0_d;
         sel_b1_q <= sel_b1_d;
         dir_q    <= dir_d;
         out_q    <= out_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pad input capture; pins are taken as synchronous already
   logic [NUM_PINS-1:0] pin_q, pin_d;

   // registered so data outputs come from flip-flops
   always_comb begin
      pin_d = pad_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pin_q <= PPFM_OUT_RESET;
      end else begin
         pin_q <= pin_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // drive selection per pin
   logic [NUM_PINS-1:0] drv, drv_en;

   always_comb begin
      drv    = out_q;
      drv_en = dir_q;
      // pin a5
      case (sel_a5_q)
         PPFM_SEL_GPIO: begin
         end
         PPFM_SEL_ALT1: begin
            drv[PPFM_PIN_A5]    = motor_output_five_i;
            drv_en[PPFM_PIN_A5] = 1'b1;
         end
         PPFM_SEL_ALT2: begin
            drv[PPFM_PIN_A5]    = timer_chan_three_i;
            drv_en[PPFM_PIN_A5] = timer_chan_three_oe_i;
         end
         default: begin
            drv_en[PPFM_PIN_A5] = 1'b0; // fault input only
         end
      endcase
      // pin a6
      case (sel_a6_q)
         PPFM_SEL_GPIO: begin
         end
         PPFM_SEL_ALT2: begin
            drv[PPFM_PIN_A6]    = timer_chan_zero_i;
            drv_en[PPFM_PIN_A6] = timer_chan_zero_oe_i;
         end
         default: begin
            drv_en[PPFM_PIN_A6] = 1'b0; // fault input, spare code too
         end
      endcase
      // pin b0
      case (sel_b0_q)
         PPFM_SEL_GPIO: begin
         end
         PPFM_SEL_ALT1: begin
            drv[PPFM_PIN_B0]    = spi_clock_i;
            drv_en[PPFM_PIN_B0] = spi_master_i;
         end
         PPFM_SEL_ALT2: begin
            drv[PPFM_PIN_B0]    = 1'b0;
            drv_en[PPFM_PIN_B0] = i2c_scl_low_i;
         end
         default: begin
            drv_en[PPFM_PIN_B0] = 1'b0;
         end
      endcase
      // pin b1: slave select is input only here
      case (sel_b1_q)
         PPFM_SEL_GPIO: begin
         end
         PPFM_SEL_ALT2: begin
            drv[PPFM_PIN_B1]    = 1'b0;
            drv_en[PPFM_PIN_B1] = i2c_sda_low_i;
         end
         default: begin
            drv_en[PPFM_PIN_B1] = 1'b0;
         end
      endcase
   end

   // one pad cell per pin
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pad
      ppfm_pin_cell u_cell (
         .drv_i      (drv[g]),
         .drv_en_i   (drv_en[g]),
         .pad_o      (pad_o[g]),
         .pad_oe_n_o (pad_oe_n_o[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // peripheral inputs, idle level when not selected
   // gate inputs by select
   always_comb begin
      ext_fault_in_two_o      = PPFM_FAULT_IDLE;
      ext_fault_in_zero_o     = PPFM_FAULT_IDLE;
      timer_chan_three_o      = PPFM_TIMER_IDLE;
      timer_chan_zero_o       = PPFM_TIMER_IDLE;
      timer_chan_zero_on_a6_o = 1'b0;
      spi_clock_o             = PPFM_SCLK_IDLE;
      spi_slave_select_n_o    = PPFM_SS_IDLE_N;
      i2c_scl_o               = PPFM_I2C_IDLE;
      i2c_sda_o               = PPFM_I2C_IDLE;
      if (sel_a5_q == PPFM_SEL_ALT3) begin
         ext_fault_in_two_o = pin_q[PPFM_PIN_A5];
      end
      if (sel_a6_q == PPFM_SEL_ALT1) begin
         ext_fault_in_zero_o = pin_q[PPFM_PIN_A6];
      end
      if (sel_a5_q == PPFM_SEL_ALT2) begin
         timer_chan_three_o = pin_q[PPFM_PIN_A5];
      end
      // flag tells timer which pin carries zero
      if (sel_a6_q == PPFM_SEL_ALT2) begin
         timer_chan_zero_o       = pin_q[PPFM_PIN_A6];
         timer_chan_zero_on_a6_o = 1'b1;
      end
      // slave clock input; pad hysteresis lives outside this logic
      if (sel_b0_q == PPFM_SEL_ALT1 && !spi_master_i) begin
         spi_clock_o = pin_q[PPFM_PIN_B0];
      end
      if (sel_b1_q == PPFM_SEL_ALT1 && !spi_master_i) begin
         spi_slave_select_n_o = pin_q[PPFM_PIN_B1];
      end
      if (sel_b0_q == PPFM_SEL_ALT2) begin
         i2c_scl_o = pin_q[PPFM_PIN_B0];
      end
      if (sel_b1_q == PPFM_SEL_ALT2) begin
         i2c_sda_o = pin_q[PPFM_PIN_B1];
      end
   end

   // status back to software
   always_comb begin
      sel_a5_o   = sel_a5_q;
      sel_a6_o   = sel_a6_q;
      sel_b0_o   = sel_b0_q;
      sel_b1_o   = sel_b1_q;
      gpio_dir_o = dir_q;
      gpio_in_o  = pin_q;
   end

endmodule
`default_nettype wire

/* File: dv/ppfm_pin_peer.sv */
// board-side peer of the shared pins: pull-ups and open-drain peers
`timescale 1ns/1ps
`default_nettype none
module ppfm_pin_peer (
   // design pad side
   input  wire logic [3:0] pad_o,
   input  wire logic [3:0] pad_oe_n_o,
   // peer drive and enable
   input  wire logic [3:0] peer_v_i,
   input  wire logic [3:0] peer_en_i,
   output logic      [3:0] pad_i
);
   // fault source, master select
   // wired-and so contention never hides a low
   always_comb pad_i = (pad_o | pad_oe_n_o) & (peer_v_i | ~peer_en_i);
endmodule
`default_nettype wire

/* File: dv/ppfm_checker.sv */
// assertion checker for the pin function mux
`timescale 1ns/1ps
`default_nettype none
module ppfm_checker
   import ppfm_pkg::*;
#(
   parameter int NUM_PINS = 4
) (
   // clock and reset
   input wire logic                clk_sys_i,
   input wire logic                sys_rst_i,
   // state
   input wire logic [1:0]          sel_a5_o,
   input wire logic [1:0]          sel_a6_o,
   input wire logic [1:0]          sel_b0_o,
   input wire logic [1:0]          sel_b1_o,
   input wire logic [NUM_PINS-1:0] gpio_dir_o,
   input wire logic [NUM_PINS-1:0] gpio_in_o,
   // peripherals
   input wire logic                motor_output_five_i,
   input wire logic                ext_fault_in_zero_o,
   input wire logic                ext_fault_in_two_o,
   input wire logic                timer_chan_three_oe_i,
   input wire logic                timer_chan_three_o,
   input wire logic                timer_chan_zero_on_a6_o,
   input wire logic                spi_master_i,
   input wire logic                spi_clock_o,
   input wire logic                spi_slave_select_n_o,
   input wire logic                i2c_scl_low_i,
   // pads
   input wire logic [NUM_PINS-1:0] pad_o,
   input wire logic [NUM_PINS-1:0] pad_oe_n_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   AST_RST: assert property ($fell(sys_rst_i) |-> {sel_a5_o, sel_a6_o, sel_b0_o, sel_b1_o} == 8'h00
      && gpio_dir_o == 4'h0 && &pad_oe_n_o) else $error("reset state wrong");
   AST_GPIO: assert property (sel_b1_o == PPFM_SEL_GPIO |-> pad_oe_n_o[3] == !gpio_dir_o[3])
      else $error("gpio direction not on pad");
   AST_FLT: assert property (ext_fault_in_two_o == (sel_a5_o == 2'h3 && gpio_in_o[0])
      && ext_fault_in_zero_o == (sel_a6_o == 2'h1 && gpio_in_o[1])) else $error("fault path wrong");
   AST_MOT: assert property (sel_a5_o == 2'h1 |-> !pad_oe_n_o[0] && pad_o[0] == motor_output_five_i)
      else $error("motor output not driven");
   AST_SCK: assert property (sel_b0_o == 2'h1 |-> pad_oe_n_o[2] == !spi_master_i
      && spi_clock_o == (!spi_master_i && gpio_in_o[2])) else $error("spi clock direction wrong");
   AST_SS: assert property (sel_b1_o == 2'h1 && !spi_master_i |-> spi_slave_select_n_o == gpio_in_o[3])
      else $error("slave select not passed");
   AST_I2C: assert property (sel_b0_o == 2'h2 |-> !pad_o[2] && pad_oe_n_o[2] == !i2c_scl_low_i)
      else $error("i2c clock not open drain");
   AST_T3: assert property (sel_a5_o == 2'h2 |-> pad_oe_n_o[0] == !timer_chan_three_oe_i
      && timer_chan_three_o == gpio_in_o[0]) else $error("timer three path wrong");
   AST_T0: assert property (timer_chan_zero_on_a6_o == (sel_a6_o == 2'h2))
      else $error("timer zero pin flag wrong");
   // main scenarios reached
   COV_MOT: cover property (sel_a5_o == 2'h1);
   COV_SLV: cover property (sel_b1_o == 2'h1 && !spi_master_i);
   COV_I2C: cover property (sel_b0_o == 2'h2 && i2c_scl_low_i);
endmodule
bind ppfm_mux ppfm_checker #(.NUM_PINS(NUM_PINS)) u_chk (.*);
`default_nettype wire

/* File: dv/tb_top.sv */
// random and corner tests of the pin function mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top;
   import ppfm_pkg::*;
   logic        clk_sys_i = 0;
   logic        sys_rst_i = 1;
   logic        sel_wr = 0, gpio_wr = 0, mst = 0;
   logic [7:0]  sel = 0, drv = 0, sel_o, s = 0, per;
   logic [3:0]  dir = 0, out = 0, pv = 0, pe = 0, pad_i, pad_o, oe_n, dir_o, in_o;
   logic [3:0]  d = 0, o = 0, pq = 0, cap;
   logic        ssn;
   logic [31:0] r;
   int          seed = 97, bad_count = 0, tests_run = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   ppfm_mux u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sel_wr_i(sel_wr),
      .sel_a5_i(sel[1:0]), .sel_a6_i(sel[3:2]), .sel_b0_i(sel[5:4]), .sel_b1_i(sel[7:6]),
      .sel_a5_o(sel_o[1:0]), .sel_a6_o(sel_o[3:2]), .sel_b0_o(sel_o[5:4]), .sel_b1_o(sel_o[7:6]),
      .gpio_wr_i(gpio_wr), .gpio_dir_i(dir), .gpio_out_i(out), .gpio_dir_o(dir_o), .gpio_in_o(in_o),
      .motor_output_five_i(drv[0]), .ext_fault_in_zero_o(per[6]), .ext_fault_in_two_o(per[7]),
      .timer_chan_three_i(drv[1]), .timer_chan_three_oe_i(drv[2]), .timer_chan_three_o(per[5]),
      .timer_chan_zero_i(drv[3]), .timer_chan_zero_oe_i(drv[4]), .timer_chan_zero_o(per[4]),
      .timer_chan_zero_on_a6_o(per[3]), .spi_master_i(mst), .spi_clock_i(drv[5]), .spi_clock_o(per[2]),
      .spi_slave_select_n_o(ssn), .i2c_scl_low_i(drv[6]), .i2c_sda_low_i(drv[7]), .i2c_scl_o(per[1]),
      .i2c_sda_o(per[0]), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n_o(oe_n));
   ppfm_pin_peer u_peer (.pad_o(pad_o), .pad_oe_n_o(oe_n), .peer_v_i(pv), .peer_en_i(pe), .pad_i(pad_i));
   // verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // pad enable and value per pin from the rules; returns {oe_n, pad}
   function automatic logic [7:0] exp_pad(input logic [7:0] sv, input logic [3:0] dv, ov,
                                          input logic [7:0] dr, input logic m);
      logic [3:0] en, v;
      en[0] = (sv[1:0] == PPFM_SEL_GPIO) ? dv[0] : (sv[1:0] == PPFM_SEL_ALT1) ? 1'b1 :
              (sv[1:0] == PPFM_SEL_ALT2) ? dr[2] : 1'b0;
      v[0]  = (sv[1:0] == PPFM_SEL_GPIO) ? ov[0] : (sv[1:0] == PPFM_SEL_ALT1) ? dr[0] : dr[1];
      en[1] = (sv[3:2] == PPFM_SEL_GPIO) ? dv[1] : (sv[3:2] == PPFM_SEL_ALT2) ? dr[4] : 1'b0;
      v[1]  = (sv[3:2] == PPFM_SEL_GPIO) ? ov[1] : dr[3];
      en[2] = (sv[5:4] == PPFM_SEL_GPIO) ? dv[2] : (sv[5:4] == PPFM_SEL_ALT1) ? m :
              (sv[5:4] == PPFM_SEL_ALT2) ? dr[6] : 1'b0;
      v[2]  = (sv[5:4] == PPFM_SEL_GPIO) ? ov[2] : (sv[5:4] == PPFM_SEL_ALT1) ? dr[5] : 1'b0;
      en[3] = (sv[7:6] == PPFM_SEL_GPIO) ? dv[3] : (sv[7:6] == PPFM_SEL_ALT2) ? dr[7] : 1'b0;
      v[3]  = (sv[7:6] == PPFM_SEL_GPIO) ? ov[3] : 1'b0;
      return {~en, en & v};
   endfunction
   // peripheral inputs from the rules: {ext_fault_in_two, ext_fault_in_zero, t3, t0, t0 on a6, sclk, scl, sda}
   function automatic logic [7:0] exp_per(input logic [7:0] sv, input logic [3:0] q, input logic m);
      return {(sv[1:0] == PPFM_SEL_ALT3) && q[0], (sv[3:2] == PPFM_SEL_ALT1) && q[1],
              (sv[1:0] == PPFM_SEL_ALT2) && q[0], (sv[3:2] == PPFM_SEL_ALT2) && q[1],
              (sv[3:2] == PPFM_SEL_ALT2), (sv[5:4] == PPFM_SEL_ALT1) && !m && q[2],
              (sv[5:4] != PPFM_SEL_ALT2) || q[2], (sv[7:6] != PPFM_SEL_ALT2) || q[3]};
   endfunction
   // stimulus at the falling edge, shadow state updated per rising edge
   initial begin
      repeat (2) @(negedge clk_sys_i);
      sys_rst_i = 0;
      `CHK("pad_oe_n", 4'hF, oe_n)
      for (int i = 0; i < 400; i++) begin
         `CHK("sel_o", s, sel_o)
         `CHK("dir_o", d, dir_o)
         `CHK("in_o", pq, in_o)
         if (s[7:6] == 2'h1 && !mst) `CHK("ss_n", pq[3], ssn)
         `CHK("pad", exp_pad(s, d, o, drv, mst), ({oe_n, pad_o}))
         `CHK("periph", exp_per(s, pq, mst), per)
         r = $random(seed);
         {dir, out, drv, sel, sel_wr, gpio_wr, mst} = r[26:0];
         r = $random(seed);
         {pv, pe} = r[7:0];
         // one random code on every pin, first four cycles back to back
         if (i < 4) begin
            sel_wr = 1;
            sel = {4{r[9:8]}};
         end
         // reset in mid-run, writes pending
         sys_rst_i = (i == 200);
         #1 cap = pad_i;
         @(posedge clk_sys_i);
         if (sel_wr) s = sel;
         if (gpio_wr) begin
            d = dir;
            o = out;
         end
         pq = cap;
         if (sys_rst_i) {s, d, o, pq} = 20'h00000;
         @(negedge clk_sys_i);
      end
      end_sim();
   end
   // watchdog: five times the expected run
   initial begin
      #(400 * 5 * 5);
      bad_count++;
      end_sim();
   end
endmodule
`default_nettype wire
